/* ctl_pkg.sv */
// package: register map, field layout and event carriers of the address/speed/flush control block
package ctl_pkg;
  localparam logic [7:0] OFF_CTRL        = 8'h00;
  localparam logic [7:0] OFF_OWN_ADDR    = 8'h04;
  localparam logic [7:0] OFF_STATUS      = 8'h14;

  localparam int         CTRL_ROLE_LO    = 1;
  localparam int         CTRL_ROLE_HI    = 2;
  localparam int         CTRL_ADDR_W     = 3;
  localparam int         CTRL_SPEED_LO   = 4;
  localparam int         CTRL_SPEED_HI   = 5;
  localparam int         CTRL_GC_MODE    = 6;
  localparam int         CTRL_TX_FLUSH   = 7;
  localparam int         CTRL_RX_FLUSH   = 8;

  localparam int         OWN_SA7_LO      = 0;
  localparam int         OWN_SA7_HI      = 6;
  localparam int         OWN_EXT_LO      = 7;
  localparam int         OWN_EXT_HI      = 9;

  localparam int         ST_CODE_LO      = 0;
  localparam int         ST_CODE_HI      = 7;
  localparam int         ST_MATCH        = 8;
  localparam int         ST_TX_BUSY      = 9;
  localparam int         ST_RX_BUSY      = 10;

  localparam logic [1:0] ROLE_SLAVE      = 2'h0;
  localparam logic [1:0] ROLE_MASTER_SLV = 2'h2;
  localparam logic [1:0] SPEED_STD       = 2'h0;
  localparam logic [1:0] SPEED_FAST      = 2'h1;

  localparam logic [6:0] RST_SA7         = 7'h55;
  localparam logic [2:0] RST_EXT         = 3'h0;
  localparam logic [1:0] RST_ROLE        = 2'h0;
  localparam logic [1:0] RST_SPEED       = 2'h0;
  localparam logic [7:0] RST_CODE        = 8'h00;

  localparam int         SYNC_DEPTH      = 2;

  typedef struct packed {
    logic       valid;
    logic       ten_bit;
    logic [9:0] addr;
  } addr_event_s;

  typedef struct packed {
    logic       valid;
    logic       hw;
    logic [7:0] cmd;
  } gc_event_s;
endpackage : ctl_pkg

/* flush_handshake.sv */
// toggle handshake carrying one flush request to the serial side and its completion back
`timescale 1ns/10ps
module flush_handshake
  import ctl_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  output logic      busy,
  output logic      flush_pulse
);
  logic                  req;
  logic [SYNC_DEPTH-1:0] req_sync;
  logic                  req_seen;
  logic                  ack;
  logic [SYNC_DEPTH-1:0] ack_sync;

  // system side: request toggle, started only when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= 1'b0;
    end else if (start && !busy) begin
      req <= ~req;
    end
  end

  // serial side: synchronise request, pulse flush, return toggle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_sync    <= '0;
      req_seen    <= 1'b0;
      flush_pulse <= 1'b0;
      ack         <= 1'b0;
    end else begin
      req_sync    <= {req_sync[SYNC_DEPTH-2:0], req};
      req_seen    <= req_sync[SYNC_DEPTH-1];
      flush_pulse <= req_sync[SYNC_DEPTH-1] != req_seen;
      ack         <= req_seen;
    end
  end

  // system side: completion synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_sync <= '0;
    end else begin
      ack_sync <= {ack_sync[SYNC_DEPTH-2:0], ack};
    end
  end

  assign busy = req != ack_sync[SYNC_DEPTH-1];
endmodule : flush_handshake

/* addr_speed_flush_ctrl.sv */
// control register block: address width, speed class, general call handling and path flushes over apb
`timescale 1ns/10ps
// How it works
// - compare received address, 7 or 10 bit
// - speed field selects standard or fast rate
// - transparent general call goes to receive FIFO
// - direct general call executes, stores status code
// - hardware general call always passed to receive
// - transmit flush resets path, keeps configuration
// - transmit flush bit reads 1 until done
// - receive flush resets path, keeps configuration
// - receive flush bit reads 1 until done
// - role field: slave or master/slave addressable
module addr_speed_flush_ctrl
  import ctl_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire addr_event_s       rx_addr_event,
  input  wire gc_event_s         rx_gc_event,
  output logic                   addr_match,
  output logic                   gc_to_rx_fifo,
  output logic                   gc_direct_exec,
  output logic      [7:0]        gc_direct_cmd,
  output logic                   speed_fast,
  output logic      [1:0]        bus_speed_select,
  output logic                   tx_path_reset,
  output logic                   rx_path_reset
);
  if (ADDR_W < 8) begin : g_addr_w_check
    $error("ADDR_W must be at least 8");
  end

  logic [1:0] role_select;
  logic       slave_addr_width_sel;
  logic       general_call_handling;
  logic [6:0] own_sa7;
  logic [2:0] own_ext;
  logic [7:0] status_code;
  logic       tx_path_flush;
  logic       rx_path_flush;
  logic       wr_ctrl;
  logic       wr_own;
  logic       access;
  logic       mapped;
  logic       addressable;
  logic [7:0] word_addr;
  logic [31:0] next_prdata;
  logic       gc_direct;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = a == off;
  endfunction : addr_hit

  function automatic logic gc_direct_call(input gc_event_s ev, input logic handling);
    gc_direct_call = ev.valid && !ev.hw && handling;
  endfunction : gc_direct_call

  assign word_addr = paddr[7:0];
  assign access    = psel && penable;
  assign mapped    = addr_hit(word_addr, OFF_CTRL) || addr_hit(word_addr, OFF_OWN_ADDR) ||
                     addr_hit(word_addr, OFF_STATUS);
  assign pready    = 1'b1;
  assign pslverr   = access && (!mapped || (pwrite && addr_hit(word_addr, OFF_STATUS)));
  assign wr_ctrl   = access && pwrite && addr_hit(word_addr, OFF_CTRL);
  assign wr_own    = access && pwrite && addr_hit(word_addr, OFF_OWN_ADDR);
  assign gc_direct = gc_direct_call(rx_gc_event, general_call_handling);

  // configuration fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      role_select           <= RST_ROLE;
      slave_addr_width_sel  <= 1'b0;
      bus_speed_select      <= RST_SPEED;
      general_call_handling <= 1'b0;
    end else if (wr_ctrl) begin
      role_select           <= pwdata[CTRL_ROLE_HI:CTRL_ROLE_LO];
      slave_addr_width_sel  <= pwdata[CTRL_ADDR_W];
      bus_speed_select      <= pwdata[CTRL_SPEED_HI:CTRL_SPEED_LO];
      general_call_handling <= pwdata[CTRL_GC_MODE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_sa7 <= RST_SA7;
      own_ext <= RST_EXT;
    end else if (wr_own) begin
      own_sa7 <= pwdata[OWN_SA7_HI:OWN_SA7_LO];
      own_ext <= pwdata[OWN_EXT_HI:OWN_EXT_LO];
    end
  end

  // speed class decode; codes other than fast fall back to standard
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_fast <= 1'b0;
    end else begin
      speed_fast <= bus_speed_select == SPEED_FAST;
    end
  end

  // flush commands, held busy through the handshake
  flush_handshake u_tx_flush (
    .pclk        (pclk),
    .presetn     (presetn),
    .start       (wr_ctrl && pwdata[CTRL_TX_FLUSH]),
    .busy        (tx_path_flush),
    .flush_pulse (tx_path_reset)
  );

  flush_handshake u_rx_flush (
    .pclk        (pclk),
    .presetn     (presetn),
    .start       (wr_ctrl && pwdata[CTRL_RX_FLUSH]),
    .busy        (rx_path_flush),
    .flush_pulse (rx_path_reset)
  );

  // address matching in slave and master/slave roles
  assign addressable = role_select == ROLE_SLAVE || role_select == ROLE_MASTER_SLV;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_match <= 1'b0;
    end else if (rx_addr_event.valid) begin
      if (!addressable) begin
        addr_match <= 1'b0;
      end else if (slave_addr_width_sel) begin
        addr_match <= rx_addr_event.ten_bit && rx_addr_event.addr == {own_ext, own_sa7};
      end else begin
        addr_match <= !rx_addr_event.ten_bit && rx_addr_event.addr[6:0] == own_sa7;
      end
    end
  end

  // general call routing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gc_to_rx_fifo  <= 1'b0;
      gc_direct_exec <= 1'b0;
      gc_direct_cmd  <= 8'h00;
      status_code    <= RST_CODE;
    end else begin
      gc_to_rx_fifo  <= rx_gc_event.valid && (rx_gc_event.hw || !general_call_handling);
      gc_direct_exec <= gc_direct;
      if (gc_direct) begin
        gc_direct_cmd <= rx_gc_event.cmd;
        status_code   <= rx_gc_event.cmd;
      end
    end
  end

  // read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (addr_hit(word_addr, OFF_CTRL)) begin
      next_prdata[CTRL_ROLE_HI:CTRL_ROLE_LO]   = role_select;
      next_prdata[CTRL_ADDR_W]                 = slave_addr_width_sel;
      next_prdata[CTRL_SPEED_HI:CTRL_SPEED_LO] = bus_speed_select;
      next_prdata[CTRL_GC_MODE]                = general_call_handling;
      next_prdata[CTRL_TX_FLUSH]               = tx_path_flush;
      next_prdata[CTRL_RX_FLUSH]               = rx_path_flush;
    end else if (addr_hit(word_addr, OFF_OWN_ADDR)) begin
      next_prdata[OWN_SA7_HI:OWN_SA7_LO] = own_sa7;
      next_prdata[OWN_EXT_HI:OWN_EXT_LO] = own_ext;
    end else if (addr_hit(word_addr, OFF_STATUS)) begin
      next_prdata[ST_CODE_HI:ST_CODE_LO] = status_code;
      next_prdata[ST_MATCH]              = addr_match;
      next_prdata[ST_TX_BUSY]            = tx_path_flush;
      next_prdata[ST_RX_BUSY]            = rx_path_flush;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_addr_seven: assert property (
    rx_addr_event.valid && addressable && !slave_addr_width_sel && !rx_addr_event.ten_bit &&
    rx_addr_event.addr[6:0] == own_sa7 |=> addr_match)
    else $error("7-bit address not matched");

  a_addr_ten: assert property (
    rx_addr_event.valid && slave_addr_width_sel && !rx_addr_event.ten_bit |=> !addr_match)
    else $error("7-bit header matched in 10-bit mode");

  a_role_master: assert property (
    rx_addr_event.valid && role_select == 2'h1 |=> !addr_match)
    else $error("master-only role matched an address");

  a_speed_class: assert property (
    ##1 $stable(bus_speed_select) |-> speed_fast == (bus_speed_select == SPEED_FAST))
    else $error("speed class wrong");

  a_gc_transparent: assert property (
    rx_gc_event.valid && !general_call_handling |=> gc_to_rx_fifo && !gc_direct_exec)
    else $error("transparent general call not passed on");

  a_gc_direct: assert property (
    rx_gc_event.valid && !rx_gc_event.hw && general_call_handling |=>
    gc_direct_exec && !gc_to_rx_fifo && status_code == $past(rx_gc_event.cmd))
    else $error("direct general call not executed");

  a_gc_hardware: assert property (
    rx_gc_event.valid && rx_gc_event.hw |=> gc_to_rx_fifo && !gc_direct_exec)
    else $error("hardware general call not transparent");

  a_tx_flush_run: assert property (
    wr_ctrl && pwdata[CTRL_TX_FLUSH] && !tx_path_flush |=> tx_path_flush ##[1:4] tx_path_reset ##[1:6] !tx_path_flush)
    else $error("transmit flush sequence wrong");

  a_rx_flush_run: assert property (
    wr_ctrl && pwdata[CTRL_RX_FLUSH] && !rx_path_flush |=> rx_path_flush ##[1:4] rx_path_reset ##[1:6] !rx_path_flush)
    else $error("receive flush sequence wrong");

  a_flush_keeps_cfg: assert property (
    (tx_path_reset || rx_path_reset) && !wr_ctrl |=> $stable(bus_speed_select) && $stable(role_select))
    else $error("flush changed configuration");

  a_ctrl_write: assert property (
    wr_ctrl |=> bus_speed_select == $past(pwdata[CTRL_SPEED_HI:CTRL_SPEED_LO]) &&
    role_select == $past(pwdata[CTRL_ROLE_HI:CTRL_ROLE_LO]) &&
    slave_addr_width_sel == $past(pwdata[CTRL_ADDR_W]) && general_call_handling == $past(pwdata[CTRL_GC_MODE]))
    else $error("control write did not land");

  a_ctrl_hold: assert property (
    !wr_ctrl |=> $stable(role_select) && $stable(slave_addr_width_sel) &&
    $stable(bus_speed_select) && $stable(general_call_handling))
    else $error("control fields changed without a write");

  a_own_write: assert property (
    wr_own |=> own_sa7 == $past(pwdata[OWN_SA7_HI:OWN_SA7_LO]) && own_ext == $past(pwdata[OWN_EXT_HI:OWN_EXT_LO]))
    else $error("own address write did not land");

  a_own_hold: assert property (
    !wr_own |=> $stable(own_sa7) && $stable(own_ext))
    else $error("own address changed without a write");

  a_addr_ten_hit: assert property (
    rx_addr_event.valid && addressable && slave_addr_width_sel && rx_addr_event.ten_bit &&
    rx_addr_event.addr == {own_ext, own_sa7} |=> addr_match)
    else $error("10-bit address not matched");

  a_addr_seven_miss: assert property (
    rx_addr_event.valid && !slave_addr_width_sel && rx_addr_event.addr[6:0] != own_sa7 |=> !addr_match)
    else $error("foreign 7-bit address matched");

  a_addr_hold: assert property (
    !rx_addr_event.valid |=> $stable(addr_match))
    else $error("match result changed without an address");

  a_role_other: assert property (
    rx_addr_event.valid && !addressable |=> !addr_match)
    else $error("non-addressable role matched an address");

  a_speed_std: assert property (
    bus_speed_select != SPEED_FAST |=> !speed_fast)
    else $error("standard speed code gave fast class");

  a_speed_fast: assert property (
    bus_speed_select == SPEED_FAST |=> speed_fast)
    else $error("fast speed code gave standard class");

  a_gc_idle: assert property (
    !rx_gc_event.valid |=> !gc_to_rx_fifo && !gc_direct_exec)
    else $error("general call output without an event");

  a_gc_code_hold: assert property (
    !gc_direct |=> $stable(status_code))
    else $error("status code changed without a direct call");

  a_gc_cmd_out: assert property (
    gc_direct |=> gc_direct_cmd == $past(rx_gc_event.cmd))
    else $error("direct call command not presented");

  a_tx_pulse_once: assert property (
    tx_path_reset |=> !tx_path_reset)
    else $error("transmit path reset longer than one cycle");

  a_rx_pulse_once: assert property (
    rx_path_reset |=> !rx_path_reset)
    else $error("receive path reset longer than one cycle");

  a_tx_busy_pulse: assert property (
    tx_path_reset |-> tx_path_flush)
    else $error("transmit path reset while flush bit clear");

  a_rx_busy_pulse: assert property (
    rx_path_reset |-> rx_path_flush)
    else $error("receive path reset while flush bit clear");

  a_tx_flush_read: assert property (
    psel && !penable && !pwrite && addr_hit(word_addr, OFF_CTRL) |=>
    prdata[CTRL_TX_FLUSH] == $past(tx_path_flush))
    else $error("transmit flush bit read wrong");

  a_rx_flush_read: assert property (
    psel && !penable && !pwrite && addr_hit(word_addr, OFF_CTRL) |=>
    prdata[CTRL_RX_FLUSH] == $past(rx_path_flush))
    else $error("receive flush bit read wrong");

  a_status_read: assert property (
    psel && !penable && !pwrite && addr_hit(word_addr, OFF_STATUS) |=>
    prdata[ST_CODE_HI:ST_CODE_LO] == $past(status_code) && prdata[ST_MATCH] == $past(addr_match))
    else $error("status read wrong");
endmodule : addr_speed_flush_ctrl

/* rx_partner.sv */
// receiver-side partner model: emits address and general call events
`timescale 1ns/10ps
module rx_partner
  import ctl_pkg::*;
(
  input  wire logic pclk,
  output addr_event_s addr_ev,
  output gc_event_s   gc_ev
);
  initial begin
    addr_ev = '0;
    gc_ev   = '0;
  end
  // one-cycle pulse; released fields show the inverse, never a stale value
  task automatic send_addr(input logic ten, input logic [9:0] a);
    addr_ev <= '{1'b1, ten, a};
    @(posedge pclk);
    addr_ev <= '{1'b0, ~ten, ~a};
  endtask : send_addr
  task automatic send_gc(input logic hw, input logic [7:0] c);
    gc_ev <= '{1'b1, hw, c};
    @(posedge pclk);
    gc_ev <= '{1'b0, ~hw, ~c};
  endtask : send_gc
endmodule : rx_partner

/* tb_top.sv */
// self-checking bench for the address, speed and flush control block
`timescale 1ns/10ps
module tb_top;
  import ctl_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, gc_direct_cmd, code = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'd5138;
  logic        pready, pslverr, addr_match, gc_to_rx_fifo, gc_direct_exec, speed_fast;
  logic        tx_path_reset, rx_path_reset, skip = 1'b0, ev_seen = 1'b0, exp_match = 1'b0;
  logic [1:0]  bus_speed_select;
  logic [9:0]  own;
  addr_event_s addr_ev;
  gc_event_s   gc_ev;
  logic [32:0] bus_q[$];
  logic [10:0] ev_q[$];
  int          num_errors = 0, samples_checked = 0, tx_pulses = 0, rx_pulses = 0;

  always #25 pclk = ~pclk;

  addr_speed_flush_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_addr_event(addr_ev), .rx_gc_event(gc_ev), .addr_match(addr_match),
    .gc_to_rx_fifo(gc_to_rx_fifo), .gc_direct_exec(gc_direct_exec), .gc_direct_cmd(gc_direct_cmd),
    .speed_fast(speed_fast), .bus_speed_select(bus_speed_select), .tx_path_reset(tx_path_reset),
    .rx_path_reset(rx_path_reset));
  rx_partner i_rx (.pclk(pclk), .addr_ev(addr_ev), .gc_ev(gc_ev));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    bus_q.push_back({err, 32'h0});
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic err);
    bus_q.push_back({err, exp});
    apb(1'b0, a, 32'h0);
  endtask : rdc

  // bus results and event results are compared against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !skip) chk({pslverr, pwrite ? 32'h0 : prdata}, bus_q.pop_front());
    ev_seen <= addr_ev.valid | gc_ev.valid;
    if (ev_seen) chk({22'h0, addr_match, gc_to_rx_fifo, gc_direct_exec,
                      gc_direct_exec ? gc_direct_cmd : 8'h00}, {22'h0, ev_q.pop_front()});
    if (tx_path_reset === 1'b1) tx_pulses++;
    if (rx_path_reset === 1'b1) rx_pulses++;
  end

  task automatic cfg(input logic [1:0] role, input logic aw, input logic [1:0] sp, input logic gcm);
    wr(OFF_CTRL, {25'h0, gcm, sp, aw, role, 1'b0}, 1'b0);
    rdc(OFF_CTRL, {25'h0, gcm, sp, aw, role, 1'b0}, 1'b0);
    chk({30'h0, speed_fast, bus_speed_select}, {30'h0, sp == SPEED_FAST, sp});
  endtask : cfg

  task automatic aev(input logic ten, input logic [9:0] a, input logic m);
    exp_match = m;
    ev_q.push_back({m, 10'h000});
    i_rx.send_addr(ten, a);
    @(posedge pclk);
  endtask : aev
  task automatic gev(input logic hw, input logic gcm, input logic [7:0] c);
    ev_q.push_back({exp_match, hw | ~gcm, ~hw & gcm, (~hw & gcm) ? c : 8'h00});
    if (~hw & gcm) code = c;
    i_rx.send_gc(hw, c);
    @(posedge pclk);
    rdc(OFF_STATUS, {23'h0, exp_match, code}, 1'b0);
  endtask : gev

  task automatic flush(input int b);
    int tx0, rx0, n;
    tx0 = tx_pulses;
    rx0 = rx_pulses;
    wr(OFF_CTRL, 32'h5C | (32'h1 << b), 1'b0);
    rdc(OFF_CTRL, 32'h5C | (32'h1 << b), 1'b0);
    skip = 1'b1;
    n = 0;
    do begin
      apb(1'b0, OFF_CTRL, 32'h0);
      n++;
    end while (rd[b] !== 1'b0 && n < 40);
    skip = 1'b0;
    chk(33'(n < 40), 33'h1);
    chk(33'(tx_pulses - tx0), 33'(b == CTRL_TX_FLUSH));
    chk(33'(rx_pulses - rx0), 33'(b == CTRL_RX_FLUSH));
    rdc(OFF_CTRL, 32'h5C, 1'b0);
    rdc(OFF_OWN_ADDR, {22'h0, own}, 1'b0);
  endtask : flush

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(OFF_OWN_ADDR, {22'h0, RST_EXT, RST_SA7}, 1'b0);
    rdc(OFF_CTRL, 32'h0, 1'b0);
    wr(OFF_STATUS, 32'hFF, 1'b1);
    rdc(8'h08, 32'h0, 1'b1);
    rdc(OFF_STATUS, 32'h0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      rd = xs();
      own = rd[9:0];
      wr(OFF_OWN_ADDR, {22'h0, own}, 1'b0);
      cfg(i[2:1], i[0], i[1:0] ^ i[2:1], 1'b0);
      aev(i[0], own, !i[1]);
      aev(i[0], own ^ 10'h001, 1'b0);
      aev(~i[0], own, 1'b0);
      aev(i[0], own ^ (i[0] ? 10'h200 : 10'h040), 1'b0);
      aev(i[0], own, !i[1]);
    end
    for (int g = 0; g < 4; g++) begin
      cfg(ROLE_SLAVE, 1'b0, SPEED_FAST, g[1]);
      rd = xs();
      gev(g[0], g[1], rd[7:0]);
    end
    cfg(ROLE_MASTER_SLV, 1'b1, SPEED_FAST, 1'b1);
    flush(CTRL_TX_FLUSH);
    flush(CTRL_RX_FLUSH);
    repeat (3) @(posedge pclk);
    chk(33'(ev_q.size() + bus_q.size()), 33'h0);
    tally_and_finish();
  end
endmodule : tb_top
